// >>> logic/bsr_core.sv
// burst-of-four split-port ddr sram: address slots, self-timed writes, read pipeline, echo
// assumes the controller drives the link clock pair and all link pins on that pair;
// i_clock is unrelated and only filters the static bypass pin; i_rst is synchronised on the link clock directly

`timescale 1ns/1ps

module bsr_core #(
	parameter int ADDR_W = bsr_pkg::ADDR_W // burst address bits, shrink for simulation
) (
	input  wire logic                       i_clock,                // system clock
	input  wire logic                       i_rst,                  // system reset
	input  wire logic                       i_link_clk,             // positive link clock
	input  wire logic                       i_link_clk_n,           // inverted link clock
	input  wire logic                       i_pll_bypass_select,    // high: pll mode
	input  wire logic                       i_read_port_select_n,   // read select
	input  wire logic                       i_write_port_select_n,  // write select
	input  wire logic [ADDR_W-1:0]          i_address,              // shared address
	input  wire bsr_pkg::bsr_word_t          i_write_data,           // write data pins
	input  wire bsr_pkg::bsr_lane_t          i_byte_lane_enable_n,   // byte enables
	output bsr_pkg::bsr_word_t               o_read_data_rise,       // word launched on rise
	output logic                            o_read_drive_rise,      // its output enable
	output logic                            o_read_valid_flag_rise, // its valid flag
	output bsr_pkg::bsr_word_t               o_read_data_fall,       // word launched on fall
	output logic                            o_read_drive_fall,      // its output enable
	output logic                            o_read_valid_flag_fall, // its valid flag
	output logic                            o_echo_timing_out,      // echo toggle, rise
	output logic                            o_echo_timing_out_n     // echo toggle, fall
);

	localparam int IDX_W = ADDR_W + bsr_pkg::BEAT_W;       // word index width
	localparam int DEPTH = (2 ** ADDR_W) * bsr_pkg::BURST_LEN; // words in the array

	////////////////////////////////////////////////////////////////////////////////
	// link side state
	typedef struct packed {
		logic [bsr_pkg::SYNC_STAGES-1:0]                       rst_pipe;  // reset crossing
		logic [bsr_pkg::SYNC_STAGES-1:0]                       pll_bypass_select_pipe; // bypass crossing
		bsr_pkg::bsr_slot_e                                    slot;      // address slot
		logic                                                  rd_pend;   // read to fetch
		logic [ADDR_W-1:0]                                     rd_addr;   // its address
		logic                                                  rd_active; // last read select
		bsr_pkg::bsr_wr_e                                      wr_state;  // commit phase
		logic [ADDR_W-1:0]                                     wr_addr;   // write address
		bsr_pkg::bsr_word_t                                    in_data;   // rise data reg
		bsr_pkg::bsr_lane_t                                    in_be_n;   // rise enables reg
		logic [bsr_pkg::QUEUE_HALVES-1:0]                      q_valid;   // future halves
		logic [bsr_pkg::QUEUE_HALVES-1:0][bsr_pkg::WORD_W-1:0] q_word;    // their words
		bsr_pkg::bsr_word_t                                    rise_word; // rise output
		logic                                                  rise_valid;
		logic                                                  rise_drive;
		bsr_pkg::bsr_word_t                                    fall_word; // to fall stage
		logic                                                  fall_valid;
		logic                                                  fall_drive;
		logic                                                  echo;      // echo toggle
	} bsr_link_s;

	bsr_pkg::bsr_core_s core_reg;   // system side state
	bsr_pkg::bsr_core_s core_next;  // its next value
	bsr_link_s          link_reg;   // link side state
	bsr_link_s          link_next;  // its next value

	bsr_pkg::bsr_word_t mem [0:DEPTH-1]; // the array, word per entry

	logic               link_rst;   // synchronised reset on the link clock
	logic               pll_mode;   // synchronised bypass select
	bsr_pkg::bsr_word_t fall_wdata; // write word taken on the inverted clock
	bsr_pkg::bsr_lane_t fall_be_n;  // its byte enables

	// array write port, driven by the self-timed commit
	logic               wr_en;
	logic [IDX_W-1:0]   wr_idx_a;   // even word of the pair
	logic [IDX_W-1:0]   wr_idx_b;   // odd word of the pair
	bsr_pkg::bsr_word_t wr_word_a;
	bsr_pkg::bsr_word_t wr_word_b;

	// burst fetched this edge, with forwarding applied
	logic [bsr_pkg::BURST_LEN-1:0][bsr_pkg::WORD_W-1:0] burst;

	assign link_rst = link_reg.rst_pipe[bsr_pkg::SYNC_STAGES-1];
	assign pll_mode = link_reg.pll_bypass_select_pipe[bsr_pkg::SYNC_STAGES-1];

	////////////////////////////////////////////////////////////////////////////////
	// system clock side: filter the static bypass pin
	// the pin changes only between frames, so a slow filter costs nothing
	always_comb begin
		core_next           = core_reg;
		core_next.pll_bypass_select_pipe = {core_reg.pll_bypass_select_pipe[bsr_pkg::PIN_STAGES-2:0], i_pll_bypass_select};
		// change counts once the two later stages agree
		if (core_reg.pll_bypass_select_pipe[bsr_pkg::PIN_STAGES-1] ==
			core_reg.pll_bypass_select_pipe[bsr_pkg::PIN_STAGES-2]) begin
			core_next.pll_bypass_select_stable = core_reg.pll_bypass_select_pipe[bsr_pkg::PIN_STAGES-1];
		end
		if (i_rst) begin
			core_next.pll_bypass_select_stable = bsr_pkg::PLL_BYPASS_SELECT_RESET;
		end
	end

	// system clock register bank
	always_ff @(posedge i_clock) begin
		core_reg <= core_next;
	end

	////////////////////////////////////////////////////////////////////////////////
	// array write pair for this edge
	// lanes left disabled keep their stored value via the merge
	always_comb begin
		wr_en    = (link_reg.wr_state != bsr_pkg::WR_IDLE) && !link_rst;
		wr_idx_a = {link_reg.wr_addr, bsr_pkg::BEAT_LOW_PAIR};
		if (link_reg.wr_state == bsr_pkg::WR_HIGH) begin
			wr_idx_a = {link_reg.wr_addr, bsr_pkg::BEAT_HIGH_PAIR};
		end
		wr_idx_b  = wr_idx_a | IDX_W'(1);
		wr_word_a = bsr_pkg::bsr_merge(mem[wr_idx_a], link_reg.in_data, link_reg.in_be_n);
		wr_word_b = bsr_pkg::bsr_merge(mem[wr_idx_b], fall_wdata, fall_be_n);
	end

	// array update, two words per link cycle, no strobe from outside
	always_ff @(posedge i_link_clk) begin
		if (wr_en) begin
			mem[wr_idx_a] <= wr_word_a;
			mem[wr_idx_b] <= wr_word_b;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// burst fetch with forwarding
	// a write latched one slot earlier still commits its upper pair on this edge,
	// so those two words are taken from the write path instead of the array
	localparam logic [bsr_pkg::BEAT_W-1:0] BEAT_ONE = 2'h1; // step to the odd word
	always_comb begin
		for (int k = 0; k < bsr_pkg::BURST_LEN; k++) begin
			burst[k] = mem[{link_reg.rd_addr, bsr_pkg::BEAT_W'(k)}];
		end
		if (wr_en && (link_reg.wr_state == bsr_pkg::WR_HIGH) &&
			(link_reg.wr_addr == link_reg.rd_addr)) begin
			burst[bsr_pkg::BEAT_HIGH_PAIR]              = wr_word_a;
			burst[bsr_pkg::BEAT_HIGH_PAIR + BEAT_ONE]   = wr_word_b;
		end
	end


	////////////////////////////////////////////////////////////////////////////////
	// link side next state
	always_comb begin
		logic [bsr_pkg::SPAN_HALVES-1:0]                      h_valid; // halves from this edge
		logic [bsr_pkg::SPAN_HALVES-1:0][bsr_pkg::WORD_W-1:0] h_word;
		logic [bsr_pkg::SYNC_STAGES-1:0]                      rst_p;
		logic [bsr_pkg::SYNC_STAGES-1:0]                      pll_bypass_select_p;
		int                                                   off;
		h_valid = '0;
		h_word  = '0;
		rst_p   = {link_reg.rst_pipe[bsr_pkg::SYNC_STAGES-2:0], i_rst};
		pll_bypass_select_p  = {link_reg.pll_bypass_select_pipe[bsr_pkg::SYNC_STAGES-2:0], core_reg.pll_bypass_select_stable};
		off     = bsr_pkg::BYPASS_OFFSET;

		link_next           = link_reg;
		link_next.rst_pipe  = rst_p;
		link_next.pll_bypass_select_pipe = pll_bypass_select_p;
		link_next.echo      = ~link_reg.echo;
		link_next.in_data   = i_write_data;
		link_next.in_be_n   = i_byte_lane_enable_n;

		// address slots alternate read, write, read, ...
		if (link_reg.slot == bsr_pkg::SLOT_READ) begin
			link_next.slot = bsr_pkg::SLOT_WRITE;
		end else begin
			link_next.slot = bsr_pkg::SLOT_READ;
		end

		// read slot: select sampled, address taken only when selected
		link_next.rd_pend = 1'b0;
		if (link_reg.slot == bsr_pkg::SLOT_READ) begin
			link_next.rd_active = ~i_read_port_select_n;
			if (!i_read_port_select_n) begin
				link_next.rd_pend = 1'b1;
				link_next.rd_addr = i_address;
			end
		end

		// write engine: low pair next edge, high pair the edge after
		unique case (link_reg.wr_state)
			bsr_pkg::WR_IDLE: begin
				link_next.wr_state = bsr_pkg::WR_IDLE;
			end
			bsr_pkg::WR_LOW: begin
				link_next.wr_state = bsr_pkg::WR_HIGH;
			end
			bsr_pkg::WR_HIGH: begin
				link_next.wr_state = bsr_pkg::WR_IDLE;
			end
			default: begin
				link_next.wr_state = bsr_pkg::WR_IDLE; // illegal code
			end
		endcase
		// a deselected write port ignores address and data
		if ((link_reg.slot == bsr_pkg::SLOT_WRITE) && !i_write_port_select_n) begin
			link_next.wr_state = bsr_pkg::WR_LOW;
			link_next.wr_addr  = i_address;
		end

		// read pipeline: queued halves, then the new burst overlaid
		for (int i = 0; i < bsr_pkg::QUEUE_HALVES; i++) begin
			h_valid[i] = link_reg.q_valid[i];
			h_word[i]  = link_reg.q_word[i];
		end
		if (pll_mode) begin
			off = bsr_pkg::PLL_OFFSET;
		end else begin
			off = bsr_pkg::BYPASS_OFFSET;
		end
		if (link_reg.rd_pend) begin
			for (int k = 0; k < bsr_pkg::BURST_LEN; k++) begin
				h_valid[off + k] = 1'b1;
				h_word[off + k]  = burst[k];
			end
		end

		// this edge launches halves 0 and 1, the rest moves down
		link_next.rise_word  = h_word[0];
		link_next.rise_valid = h_valid[0];
		link_next.fall_word  = h_word[1];
		link_next.fall_valid = h_valid[1];
		for (int i = 0; i < bsr_pkg::QUEUE_HALVES; i++) begin
			link_next.q_valid[i] = h_valid[i + bsr_pkg::HALVES_PER_CYCLE];
			link_next.q_word[i]  = h_word[i + bsr_pkg::HALVES_PER_CYCLE];
		end

		// drivers stay on while selected or a burst is still leaving
		link_next.rise_drive = h_valid[0] | link_next.rd_active;
		link_next.fall_drive = h_valid[1] | link_next.rd_active;

		// synchronous reset keeps only the crossing stages running
		if (link_rst) begin
			link_next           = '0;
			link_next.rst_pipe  = rst_p;
			link_next.pll_bypass_select_pipe = pll_bypass_select_p;
			link_next.slot      = bsr_pkg::SLOT_READ;
			link_next.wr_state  = bsr_pkg::WR_IDLE;
		end
	end

	// link clock register bank
	always_ff @(posedge i_link_clk) begin
		link_reg <= link_next;
	end

	////////////////////////////////////////////////////////////////////////////////
	// inverted clock half: write word capture and fall-half launch
	bsr_fall_stage u_fall (
		.i_link_clk_n (i_link_clk_n),
		.i_rst        (link_rst),
		.i_write_data (i_write_data),
		.i_be_n       (i_byte_lane_enable_n),
		.i_rd_word    (link_reg.fall_word),
		.i_rd_valid   (link_reg.fall_valid),
		.i_rd_drive   (link_reg.fall_drive),
		.o_echo_n     (o_echo_timing_out_n),
		.o_wdata      (fall_wdata),
		.o_be_n       (fall_be_n),
		.o_rd_word    (o_read_data_fall),
		.o_rd_valid   (o_read_valid_flag_fall),
		.o_rd_drive   (o_read_drive_fall)
	);

	////////////////////////////////////////////////////////////////////////////////
	// rise-half outputs straight from the link register bank
	assign o_read_data_rise       = link_reg.rise_word;
	assign o_read_valid_flag_rise = link_reg.rise_valid;
	assign o_read_drive_rise      = link_reg.rise_drive;
	assign o_echo_timing_out      = link_reg.echo;

endmodule : bsr_core

// >>> pkg/bsr_pkg.sv
// constants, types and helper functions shared by the burst sram core and its fall-edge stage
// assumes the link clock pair comes from the controller and i_clock is an unrelated system clock
//
// What this block does
// - read and write addresses alternate on clock rises
// - each address selects four 18-bit words
// - data crosses every half cycle on both ports
// - pll mode: first read word after 2.5 cycles
// - bypass mode: read latency is one cycle
// - read and write data ports run independently, sharing the address pins in alternate slots
// - reads return newest data, including in-flight writes
// - inputs and outputs registered on the clock pair
// - accepted writes finish without further strobes
// - valid flag marks read data periods
// - echo clocks travel with the read data
// - array holds 4 M words of 18 bits
// - active-low selects sampled on positive rise
// - two active-low byte enables per write word

package bsr_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// geometry
	localparam int WORD_W    = 18;            // bits per word
	localparam int LANE_W    = 9;             // bits per byte lane
	localparam int LANES     = 2;             // byte lanes per word
	localparam int ADDR_W    = 20;            // burst address bits
	localparam int BURST_LEN = 4;             // words per burst
	localparam int BEAT_W    = 2;             // bits to number a word in a burst

	localparam logic [BEAT_W-1:0] BEAT_LOW_PAIR  = 2'h0; // first pair of a write
	localparam logic [BEAT_W-1:0] BEAT_HIGH_PAIR = 2'h2; // second pair of a write

	////////////////////////////////////////////////////////////////////////////////
	// read latency, counted in half cycles of the link clock
	localparam int HALVES_PER_CYCLE  = 2;
	localparam int CAPTURE_HALVES    = 2;     // address latch to array read edge
	localparam int PLL_LAT_HALVES    = 5;     // 2.5 cycles
	localparam int BYPASS_LAT_HALVES = 2;     // 1 cycle
	localparam int PLL_OFFSET        = PLL_LAT_HALVES - CAPTURE_HALVES;
	localparam int BYPASS_OFFSET     = BYPASS_LAT_HALVES - CAPTURE_HALVES;
	localparam int QUEUE_HALVES      = PLL_OFFSET + BURST_LEN - HALVES_PER_CYCLE;
	localparam int SPAN_HALVES       = QUEUE_HALVES + HALVES_PER_CYCLE;

	////////////////////////////////////////////////////////////////////////////////
	// synchronisers and reset values
	localparam int   PIN_STAGES  = 3;         // static pin filter depth
	localparam int   SYNC_STAGES = 2;         // level crossing depth
	localparam logic PLL_BYPASS_SELECT_RESET  = 1'b1;      // assume pll mode until the pin settles

	////////////////////////////////////////////////////////////////////////////////
	// types
	typedef logic [WORD_W-1:0] bsr_word_t;
	typedef logic [LANES-1:0]  bsr_lane_t;

	typedef enum logic [1:0] {WR_IDLE, WR_LOW, WR_HIGH} bsr_wr_e; // write commit phase
	typedef enum logic {SLOT_READ, SLOT_WRITE} bsr_slot_e;         // address slot owner

	// state of the fall-edge stage
	typedef struct packed {
		bsr_word_t wdata;      // write word taken on the inverted clock
		bsr_lane_t be_n;       // its byte enables
		bsr_word_t rd_word;    // read word launched on the inverted clock
		logic      rd_valid;   // valid flag for that half
		logic      rd_drive;   // output enable for that half
		logic      echo_n;     // inverted echo toggle
	} bsr_fall_s;

	// state of the system clock side
	typedef struct packed {
		logic [PIN_STAGES-1:0] pll_bypass_select_pipe;   // pin filter
		logic                  pll_bypass_select_stable; // filtered bypass select
	} bsr_core_s;

	// byte-lane merge of a new word over an old one, enables active low
	function automatic bsr_word_t bsr_merge(input bsr_word_t old_w, input bsr_word_t new_w,
		input bsr_lane_t be_n);
		bsr_word_t res;
		res = old_w;
		for (int l = 0; l < LANES; l++) begin
			if (!be_n[l]) begin
				res[l*LANE_W +: LANE_W] = new_w[l*LANE_W +: LANE_W];
			end
		end
		return res;
	endfunction : bsr_merge

endpackage : bsr_pkg

// >>> logic/bsr_fall_stage.sv
// fall-edge half of the double data rate link: input and output registers on the inverted clock
// assumes its read and reset inputs come from flops on the positive link clock, half a cycle earlier; write data and enables come from the pins

`timescale 1ns/1ps

module bsr_fall_stage (
	input  wire logic              i_link_clk_n,   // inverted link clock
	input  wire logic              i_rst,          // link domain reset, synchronous
	input  wire bsr_pkg::bsr_word_t i_write_data,   // write data pins
	input  wire bsr_pkg::bsr_lane_t i_be_n,         // byte enable pins
	input  wire bsr_pkg::bsr_word_t i_rd_word,      // read word for this half
	input  wire logic              i_rd_valid,     // its valid flag
	input  wire logic              i_rd_drive,     // its output enable
	output logic                   o_echo_n,       // inverted echo toggle
	output bsr_pkg::bsr_word_t     o_wdata,        // captured write word
	output bsr_pkg::bsr_lane_t     o_be_n,         // captured byte enables
	output bsr_pkg::bsr_word_t     o_rd_word,      // launched read word
	output logic                   o_rd_valid,     // launched valid flag
	output logic                   o_rd_drive      // launched output enable
);

	bsr_pkg::bsr_fall_s fall_reg;  // all state
	bsr_pkg::bsr_fall_s fall_next; // its next value

	////////////////////////////////////////////////////////////////////////////////
	// next state: capture pins and launch the half prepared by the positive side
	always_comb begin
		fall_next          = fall_reg;
		fall_next.wdata    = i_write_data;
		fall_next.be_n     = i_be_n;
		fall_next.rd_word  = i_rd_word;
		fall_next.rd_valid = i_rd_valid;
		fall_next.rd_drive = i_rd_drive;
		fall_next.echo_n   = ~fall_reg.echo_n;
		if (i_rst) begin
			fall_next = '0;
		end
	end

	// one register bank on the inverted clock
	always_ff @(posedge i_link_clk_n) begin
		fall_reg <= fall_next;
	end

	assign o_echo_n   = fall_reg.echo_n;
	assign o_wdata    = fall_reg.wdata;
	assign o_be_n     = fall_reg.be_n;
	assign o_rd_word  = fall_reg.rd_word;
	assign o_rd_valid = fall_reg.rd_valid;
	assign o_rd_drive = fall_reg.rd_drive;

endmodule : bsr_fall_stage

// >>> bench/bsr_checker.sv
// pin assertions for the burst sram core, link clock domain
// assumes reads come only in read slots and the bypass pin moves only under reset
`timescale 1ns/1ps
module bsr_checker (
	input wire logic i_rst,
	input wire logic i_link_clk,
	input wire logic i_link_clk_n,
	input wire logic i_pll_bypass_select,
	input wire logic i_read_port_select_n,
	input wire logic o_read_drive_rise,
	input wire logic o_read_valid_flag_rise,
	input wire logic o_read_drive_fall,
	input wire logic o_read_valid_flag_fall,
	input wire logic o_echo_timing_out,
	input wire logic o_echo_timing_out_n
);
	////////////////////////////////
	logic [2:0] ok_cnt_reg; // rises since release
	// link reset lags the system reset, so wait it out
	wire ok = (ok_cnt_reg == 3'h7);
	wire acc = ok && !o_echo_timing_out && !i_read_port_select_n; // read taken
	// settle counter
	always_ff @(posedge i_link_clk) begin
		if (i_rst) begin
			ok_cnt_reg <= 3'h0;
		end else if (!ok) begin
			ok_cnt_reg <= ok_cnt_reg + 3'h1;
		end
	end
	////////////////////////////////
	default clocking cb @(posedge i_link_clk); endclocking
	default disable iff (i_rst);
	a_echo_free_run: assert property (
		ok |=> o_echo_timing_out != $past(o_echo_timing_out))
		else $error("echo stopped toggling");
	// fall toggle leaves reset half a cycle before the rise toggle,
	// so just before each inverted edge both toggles stand equal
	a_echo_pair_step: assert property (@(posedge i_link_clk_n)
		ok |-> o_echo_timing_out_n == o_echo_timing_out)
		else $error("echo pair out of step");
	a_pll_read_lat: assert property (
		acc && i_pll_bypass_select |-> ##3 o_read_valid_flag_fall
		##1 (o_read_valid_flag_rise && o_read_valid_flag_fall) ##1 o_read_valid_flag_rise)
		else $error("pll mode read latency wrong");
	a_bypass_read_lat: assert property (
		acc && !i_pll_bypass_select |-> ##2 (o_read_valid_flag_rise && o_read_valid_flag_fall)[*2])
		else $error("bypass mode read latency wrong");
	a_valid_has_cause: assert property (
		ok && o_read_valid_flag_rise |-> (i_pll_bypass_select ?
		($past(acc, 4) || $past(acc, 5)) : ($past(acc, 2) || $past(acc, 3))))
		else $error("valid flag without a read");
	a_rise_valid_driven: assert property (
		o_read_valid_flag_rise |-> o_read_drive_rise)
		else $error("valid rise half not driven");
	a_fall_valid_driven: assert property (@(posedge i_link_clk_n)
		o_read_valid_flag_fall |-> o_read_drive_fall)
		else $error("valid fall half not driven");
	a_drive_released: assert property (
		ok ##0 (!acc)[*8] |-> !o_read_drive_rise && !o_read_valid_flag_fall)
		else $error("read port still driven when idle");
endmodule : bsr_checker
bind bsr_core bsr_checker u_chk (.i_rst(i_rst), .i_link_clk(i_link_clk),
	.i_link_clk_n(i_link_clk_n), .i_pll_bypass_select(i_pll_bypass_select),
	.i_read_port_select_n(i_read_port_select_n), .o_read_drive_rise(o_read_drive_rise),
	.o_read_valid_flag_rise(o_read_valid_flag_rise), .o_read_drive_fall(o_read_drive_fall),
	.o_read_valid_flag_fall(o_read_valid_flag_fall), .o_echo_timing_out(o_echo_timing_out),
	.o_echo_timing_out_n(o_echo_timing_out_n));

// >>> bench/bsr_ctrl_model.sv
// controller model: free running link clock pair, slot aligned bursts
// assumes the core is out of reset and its echo toggles on every rise
`timescale 1ns/1ps
module bsr_ctrl_model #(
	parameter int AW = 6 // address bits in simulation
) (
	input  wire logic               i_echo,
	input  wire bsr_pkg::bsr_word_t i_rd_rise,
	input  wire logic               i_vld_rise,
	input  wire logic               i_drv_rise,
	input  wire bsr_pkg::bsr_word_t i_rd_fall,
	input  wire logic               i_vld_fall,
	input  wire logic               i_drv_fall,
	output logic                    o_k,
	output logic                    o_k_n,
	output logic                    o_rsel_n,
	output logic                    o_wsel_n,
	output logic [AW-1:0]           o_addr,
	output bsr_pkg::bsr_word_t      o_wdata,
	output bsr_pkg::bsr_lane_t      o_be_n
);
	////////////////////////////////
	// clock runs free: the core needs it during reset too
	initial begin
		o_k = 1'b0;
		o_rsel_n = 1'b1;
		o_wsel_n = 1'b1;
		o_addr = '0;
		o_wdata = '0;
		o_be_n = 2'h3;
		#7;
		forever #32 o_k = ~o_k;
	end
	assign o_k_n = ~o_k; // exact inverse, one source
	////////////////////////////////
	// optional write in slot m, optional read in slot m+1, then collect the read halves
	task automatic xfer(input logic dw, input logic [AW-1:0] wa, input bsr_pkg::bsr_word_t [3:0] w,
		input bsr_pkg::bsr_lane_t [3:0] be, input logic dr, input logic [AW-1:0] ra,
		input int lat, output bsr_pkg::bsr_word_t [3:0] q, output logic [3:0] v,
		output logic [3:0] od);
		@(posedge o_k_n);
		if (i_echo !== 1'b1) begin // next rise must be a write slot
			@(posedge o_k_n);
		end
		o_wsel_n <= ~dw;
		o_addr <= wa;
		o_wdata <= w[0];
		o_be_n <= be[0];
		@(posedge o_k);
		o_wsel_n <= 1'b1;
		o_rsel_n <= ~dr;
		o_addr <= ra;
		o_wdata <= w[1];
		o_be_n <= be[1];
		@(posedge o_k_n);
		o_wdata <= w[2];
		o_be_n <= be[2];
		@(posedge o_k);
		o_rsel_n <= 1'b1;
		o_addr <= ~ra; // released lines show the inverse, not a stale value
		o_wdata <= w[3];
		o_be_n <= be[3];
		@(posedge o_k_n);
		o_wdata <= ~w[3];
		o_be_n <= ~be[3];
		// word i stands in half lat+i after the read rise
		for (int h = 2; h <= lat + 3; h++) begin
			if (h % 2 == 0) begin
				@(posedge o_k);
			end else begin
				@(posedge o_k_n);
			end
			#1;
			if (h >= lat) begin
				q[h-lat] = (h % 2 == 0) ? i_rd_rise : i_rd_fall;
				v[h-lat] = (h % 2 == 0) ? i_vld_rise : i_vld_fall;
				od[h-lat] = (h % 2 == 0) ? i_drv_rise : i_drv_fall;
			end
		end
	endtask : xfer
endmodule : bsr_ctrl_model

// >>> bench/test_burst4_split_port_ddr_sram_interface.sv
// self-checking bench: controller model on the link pins, pll then bypass pass
// assumes the core's slot order, latencies and reset delay as handed over
`timescale 1ns/1ps
module test_burst4_split_port_ddr_sram_interface;
	typedef bsr_pkg::bsr_word_t [3:0] bsr_burst_t; // one burst of four words
	localparam int AW = 6; // small array
	logic i_clock = 1'b0;
	logic i_rst = 1'b1;
	logic pll = 1'b1; // high: pll mode
	wire k, k_n, rsel_n, wsel_n, echo, echo_n, drv_r, drv_f, vld_r, vld_f;
	wire [AW-1:0] addr;
	wire bsr_pkg::bsr_word_t wd, rd_r, rd_f;
	wire bsr_pkg::bsr_lane_t be_n;
	int errors = 0;
	int total_checks = 0;
	bsr_burst_t mem_b; // expected contents at address 9
	always #12.5 i_clock = ~i_clock;
	bsr_core #(.ADDR_W(AW)) uut (.i_clock(i_clock), .i_rst(i_rst), .i_link_clk(k),
		.i_link_clk_n(k_n), .i_pll_bypass_select(pll), .i_read_port_select_n(rsel_n),
		.i_write_port_select_n(wsel_n), .i_address(addr), .i_write_data(wd),
		.i_byte_lane_enable_n(be_n), .o_read_data_rise(rd_r), .o_read_drive_rise(drv_r),
		.o_read_valid_flag_rise(vld_r), .o_read_data_fall(rd_f), .o_read_drive_fall(drv_f),
		.o_read_valid_flag_fall(vld_f), .o_echo_timing_out(echo), .o_echo_timing_out_n(echo_n));
	bsr_ctrl_model #(.AW(AW)) ctrl (.i_echo(echo), .i_rd_rise(rd_r), .i_vld_rise(vld_r),
		.i_drv_rise(drv_r), .i_rd_fall(rd_f), .i_vld_fall(vld_f), .i_drv_fall(drv_f),
		.o_k(k), .o_k_n(k_n), .o_rsel_n(rsel_n), .o_wsel_n(wsel_n), .o_addr(addr),
		.o_wdata(wd), .o_be_n(be_n));
	////////////////////////////////
	// distinct words; s moves both lanes
	function automatic bsr_burst_t burst(input int a, input int s);
		for (int i = 0; i < 4; i++) begin
			burst[i] = bsr_pkg::bsr_word_t'((a << 8) ^ (i << 4) ^ (s * 32'h201) ^ 32'h2a5a5);
		end
	endfunction : burst
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : check
	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : finish_test
	// bypass pin moves only under reset
	task automatic do_reset(input logic mode);
		pll <= mode;
		i_rst <= 1'b1;
		repeat (11) @(posedge i_clock);
		check({echo, echo_n, drv_r, drv_f, vld_r, vld_f}, 32'h0, "quiet in reset");
		@(posedge i_clock);
		i_rst <= 1'b0;
		repeat (40) @(posedge i_clock);
	endtask : do_reset
	////////////////////////////////
	// read alone, junk on the deselected write port
	task automatic rd_cmp(input logic [AW-1:0] a, input bsr_burst_t e, input int lat);
		bsr_burst_t q;
		logic [3:0] v;
		logic [3:0] dr;
		ctrl.xfer(1'b0, ~a, ~e, 8'h00, 1'b1, a, lat, q, v, dr);
		for (int i = 0; i < 4; i++) begin
			check(q[i], e[i], "read word");
		end
		check(v, 4'hf, "valid flags");
		check(dr, 4'hf, "read drive");
	endtask : rd_cmp
	task automatic t_basic(input int lat);
		bsr_burst_t q;
		logic [3:0] v, dr;
		mem_b = burst(9, lat);
		ctrl.xfer(1'b1, 6'h09, mem_b, 8'h00, 1'b0, 6'h2a, lat, q, v, dr);
		check(v, 4'h0, "valid without read");
		rd_cmp(6'h09, mem_b, lat);
	endtask : t_basic
	// write and read of one address in adjacent slots
	task automatic t_concurrent(input int lat);
		bsr_burst_t q;
		logic [3:0] v, dr;
		mem_b = burst(9, lat + 7);
		ctrl.xfer(1'b1, 6'h09, mem_b, 8'h00, 1'b1, 6'h09, lat, q, v, dr);
		for (int i = 0; i < 4; i++) begin
			check(q[i], mem_b[i], "forwarded write");
		end
		check(v, 4'hf, "concurrent valid");
	endtask : t_concurrent
	// both lanes, high only, low only, none
	task automatic t_lanes(input int lat);
		bsr_burst_t q, nw;
		logic [3:0] v, dr;
		nw = burst(9, 3);
		ctrl.xfer(1'b1, 6'h09, nw, {2'h3, 2'h2, 2'h1, 2'h0}, 1'b0, 6'h00, lat, q, v, dr);
		mem_b[0] = nw[0];
		mem_b[1] = {nw[1][17:9], mem_b[1][8:0]};
		mem_b[2] = {mem_b[2][17:9], nw[2][8:0]};
		rd_cmp(6'h09, mem_b, lat);
	endtask : t_lanes
	// both ports deselected with live data and address
	task automatic t_ignore(input int lat);
		bsr_burst_t q;
		logic [3:0] v, dr;
		ctrl.xfer(1'b0, 6'h09, burst(9, 50), 8'h00, 1'b0, 6'h09, lat, q, v, dr);
		check(v, 4'h0, "valid while deselected");
		check(dr, 4'h0, "drive while deselected");
		rd_cmp(6'h09, mem_b, lat);
	endtask : t_ignore
	////////////////////////////////
	initial begin
		do_reset(1'b1);
		t_basic(5);
		t_concurrent(5);
		t_lanes(5);
		t_ignore(5);
		do_reset(1'b0);
		t_basic(2);
		t_concurrent(2);
		t_lanes(2);
		finish_test();
	end
	// hang guard
	initial begin
		#200000;
		errors++;
		finish_test();
	end
endmodule : test_burst4_split_port_ddr_sram_interface
